// ### hw/bgfc_pkg.sv
/*
  Package for the bridge gate and fault control block: widths, strap codes,
  reset values and timing defaults.
  Assumes a single 250 MHz system clock.
*/
package bgfc_pkg;
  localparam int BGFC_PHASES = 4;
  localparam int BGFC_AMPL_W = 8;
  localparam int BGFC_STRAP_AMPL_W = 4;
  localparam logic [3:0] BGFC_AMPL_LOW_FILL = 4'hF;
  localparam int BGFC_PWM_W = 9;
  localparam int BGFC_DEAD_W = 8;
  localparam logic [8:0] BGFC_PWM_PERIOD_RST = 9'h1FF;
  localparam logic [7:0] BGFC_DEAD_RST = 8'h04;
  localparam logic [7:0] BGFC_AMPL_RST = 8'hFF;
  localparam logic [1:0] BGFC_CODE2_RST = 2'h0;
  // Slow decay selection, ascending code order
  typedef enum logic [1:0] {
    BGFC_DECAY_NONE = 2'b00,
    BGFC_DECAY_50   = 2'b01,
    BGFC_DECAY_75   = 2'b10,
    BGFC_DECAY_87P5 = 2'b11
  } bgfc_decay_t;
  // Index of the first comparator pair, ignored in three-phase scheme
  localparam int BGFC_PAIR1 = 0;
endpackage : bgfc_pkg

// ### hw/bgfc_gate_stage.sv
/*
  One half-bridge gate stage: applies break-before-make; polarity is applied in bgfc_top.
  Assumes the on request and dead time come from the same clock domain.
*/
`timescale 1ns/1ps
module bgfc_gate_stage
  import bgfc_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Requests
  input wire logic want_high,
  input wire logic [BGFC_DEAD_W-1:0] dead_time,
  // Logical gate states, 1 means transistor on
  output logic hs_on,
  output logic ls_on
);
  logic [BGFC_DEAD_W-1:0] dead_cnt;
  logic [BGFC_DEAD_W-1:0] next_dead_cnt;
  logic side;
  logic next_side;
  logic next_hs_on;
  logic next_ls_on;

  always_comb begin
    next_side = side;
    next_dead_cnt = dead_cnt;
    next_hs_on = 1'b0;
    next_ls_on = 1'b0;
    if (want_high != side) begin
      // Both off while the new side waits out the dead time
      next_side = want_high;
      next_dead_cnt = dead_time;
    end else if (dead_cnt != '0) begin
      next_dead_cnt = dead_cnt - 1'b1;
    end else begin
      next_hs_on = side;
      next_ls_on = ~side;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      side <= 1'b0;
      dead_cnt <= BGFC_DEAD_RST;
      hs_on <= 1'b0;
      ls_on <= 1'b0;
    end else if (clk_en) begin
      side <= next_side;
      dead_cnt <= next_dead_cnt;
      hs_on <= next_hs_on;
      ls_on <= next_ls_on;
    end
  end

  a_no_overlap: assert property (@(posedge clk) disable iff (!rst_n)
    !(hs_on && ls_on)) else $error("both gates on");
endmodule : bgfc_gate_stage

// ### hw/bgfc_top.sv
/*
  Bridge gate and fault control: gate polarity, latched over-current
  shutdown, full-step comparator gating and standalone strap overrides.
  Assumes the serial decoder delivers a one-cycle fault-control write pulse
  with its clear bit, and that the waveform unit supplies phase requests.
*/
//
// Behaviour
// - High/low gate levels follow their polarity pins
// - Polarity 0 active low, 1 active high
// - Either fault input forces fault-level gates at the next edge
// - Fault stays latched until software clears
// - Fault-control write with clear bit releases latch
// - Fault-level pins set gate levels during fault
// - Fault output pin copies the latched flag
// - Gate-allow high forces fault-state gate levels
// - Full step: bridges on only without excess
// - Three-phase scheme ignores first comparator pair
// - Two-phase scheme gates each phase separately
// - PWM period and dead time are programmable
// - Standalone pin selects straps over registers
// - Strap groups are unsigned binary, suffix bit
// - Four-bit strap selects amplitude
// - Amplitude is strap high nibble, ones below
// - Two-bit strap selects slow decay
// - Decay codes: none, 50, 75, 87.5 percent
// - Straps set divider, idle reduction, regulator gain
`timescale 1ns/1ps
module bgfc_top
  import bgfc_pkg::*;
#(
  parameter int PHASES = BGFC_PHASES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Polarity and fault pins
  input wire logic high_side_polarity,
  input wire logic low_side_polarity,
  input wire logic fault_high_side_level,
  input wire logic fault_low_side_level,
  input wire logic fault_in_active_high,
  input wire logic fault_in_active_low,
  input wire logic gate_allow_n,
  // Fault-control write from the serial decoder
  input wire logic fault_ctrl_wr,
  input wire logic fault_clear_bit,
  // Motor phase requests and comparators
  input wire logic phase_scheme_select,
  input wire logic full_step_mode,
  input wire logic [PHASES-1:0] phase_drive_high,
  input wire logic [PHASES-1:0] comparator_pos_in,
  input wire logic [PHASES-1:0] comparator_neg_in,
  // Register-bank settings
  input wire logic [BGFC_PWM_W-1:0] reg_pwm_period,
  input wire logic [BGFC_DEAD_W-1:0] reg_dead_time,
  input wire logic [BGFC_AMPL_W-1:0] reg_amplitude,
  input wire logic [1:0] reg_decay_select,
  input wire logic [1:0] reg_step_divider,
  input wire logic [1:0] reg_idle_reduction,
  input wire logic [1:0] reg_regulator_gain,
  // Standalone straps
  input wire logic standalone_en,
  input wire logic [BGFC_STRAP_AMPL_W-1:0] strap_amplitude,
  input wire logic [1:0] strap_decay_select,
  input wire logic [1:0] strap_step_divider,
  input wire logic [1:0] strap_idle_reduction,
  input wire logic [1:0] strap_regulator_gain,
  // Gate outputs
  output logic [PHASES-1:0] gate_high,
  output logic [PHASES-1:0] gate_low,
  // Status and effective settings
  output logic fault_flag_out,
  output logic pwm_period_tick,
  output logic [BGFC_AMPL_W-1:0] eff_amplitude,
  output logic [1:0] eff_decay_select,
  output logic [1:0] eff_step_divider,
  output logic [1:0] eff_idle_reduction,
  output logic [1:0] eff_regulator_gain
);
  // Pin synchronisers, first stage read only by the second
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [8:0] pin_raw;
  logic fault_now_s;
  logic fault_latch;
  logic next_fault_latch;
  logic [BGFC_PWM_W-1:0] pwm_cnt;
  logic [BGFC_PWM_W-1:0] next_pwm_cnt;
  logic [PHASES-1:0] excess;
  logic [PHASES-1:0] phase_ok;
  logic [PHASES-1:0] hs_on;
  logic [PHASES-1:0] ls_on;
  logic [PHASES-1:0] next_gate_high;
  logic [PHASES-1:0] next_gate_low;
  logic shut_now;
  logic [BGFC_AMPL_W-1:0] next_amp;
  logic [1:0] next_decay;
  logic [1:0] next_div;
  logic [1:0] next_idle;
  logic [1:0] next_gain;

  // map logical state to pin level for a polarity pin
  function automatic logic pin_level(input logic on, input logic pol);
    pin_level = pol ? on : ~on;
  endfunction : pin_level

  assign pin_raw = {fault_in_active_high, fault_in_active_low, gate_allow_n,
                    high_side_polarity, low_side_polarity, fault_high_side_level,
                    fault_low_side_level, standalone_en, phase_scheme_select};

  // Two-flop synchronisers on every asynchronous pin; they keep sampling in
  // reset, since a zero reset value would fake a low-active fault and a wrong
  // polarity for the first two edges after release
  always_ff @(posedge clk) begin
    if (clk_en || !rst_n) begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end

  // synchronised fault level for the latch
  assign fault_now_s = sync2[8] | ~sync2[7];

  always_comb begin
    next_fault_latch = fault_latch;
    if (fault_ctrl_wr && fault_clear_bit)
      next_fault_latch = 1'b0;
    if (fault_now_s)
      next_fault_latch = 1'b1;
  end

  always_comb begin
    next_pwm_cnt = (pwm_cnt >= reg_pwm_period) ? '0 : pwm_cnt + 1'b1;
  end

  always_comb begin
    excess = comparator_pos_in | comparator_neg_in;
    if (sync2[0])
      excess[BGFC_PAIR1] = 1'b0;
    for (int i = 0; i < PHASES; i++) begin
      if (!full_step_mode)
        phase_ok[i] = 1'b1;
      else if (sync2[0])
        phase_ok[i] = ~|excess;
      else
        phase_ok[i] = ~excess[i];
    end
  end

  // shutdown includes raw pins so it acts at the next edge without a sync
  assign shut_now = fault_latch | fault_in_active_high | ~fault_in_active_low
                  | sync2[6];

  always_comb begin
    for (int i = 0; i < PHASES; i++) begin
      next_gate_high[i] = pin_level(hs_on[i] & phase_ok[i], sync2[5]);
      next_gate_low[i] = pin_level(ls_on[i] & phase_ok[i], sync2[4]);
    end
  end

  always_comb begin
    if (sync2[1]) begin
      next_amp = {strap_amplitude, BGFC_AMPL_LOW_FILL};
      next_decay = strap_decay_select;
      next_div = strap_step_divider;
      next_idle = strap_idle_reduction;
      next_gain = strap_regulator_gain;
    end else begin
      next_amp = reg_amplitude;
      next_decay = reg_decay_select;
      next_div = reg_step_divider;
      next_idle = reg_idle_reduction;
      next_gain = reg_regulator_gain;
    end
  end

  // Registered state and outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fault_latch <= 1'b0;
      fault_flag_out <= 1'b0;
      pwm_cnt <= '0;
      pwm_period_tick <= 1'b0;
      eff_amplitude <= BGFC_AMPL_RST;
      eff_decay_select <= BGFC_CODE2_RST;
      eff_step_divider <= BGFC_CODE2_RST;
      eff_idle_reduction <= BGFC_CODE2_RST;
      eff_regulator_gain <= BGFC_CODE2_RST;
    end else if (clk_en) begin
      fault_latch <= next_fault_latch;
      fault_flag_out <= next_fault_latch;
      pwm_cnt <= next_pwm_cnt;
      pwm_period_tick <= (next_pwm_cnt == '0);
      eff_amplitude <= next_amp;
      eff_decay_select <= next_decay;
      eff_step_divider <= next_div;
      eff_idle_reduction <= next_idle;
      eff_regulator_gain <= next_gain;
    end
  end

  // gate outputs; shutdown is forced at the next edge even with
  // clk_en low, because the raw fault pins feed shut_now without a sync
  always_ff @(posedge clk) begin
    if (!rst_n || shut_now) begin
      for (int i = 0; i < PHASES; i++) begin
        gate_high[i] <= fault_high_side_level;
        gate_low[i] <= fault_low_side_level;
      end
    end else if (clk_en) begin
      gate_high <= next_gate_high;
      gate_low <= next_gate_low;
    end
  end

  // One gate stage per phase
  for (genvar g = 0; g < PHASES; g++) begin : g_stage
    bgfc_gate_stage u_stage (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .want_high(phase_drive_high[g]),
      .dead_time(reg_dead_time),
      .hs_on(hs_on[g]),
      .ls_on(ls_on[g])
    );
  end

  sequence s_clear_write;
    fault_ctrl_wr && fault_clear_bit;
  endsequence
  sequence s_quiet;
    !fault_now_s;
  endsequence

  a_fault_sets: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && fault_now_s |=> fault_latch) else $error("fault not latched");
  a_fault_holds: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && fault_latch && !(fault_ctrl_wr && fault_clear_bit) |=> fault_latch)
    else $error("fault dropped");
  a_clear_works: assert property (@(posedge clk) disable iff (!rst_n)
    (clk_en && fault_latch) ##0 s_clear_write ##0 s_quiet |=> !fault_latch)
    else $error("clear ignored");
  a_flag_mirror: assert property (@(posedge clk) disable iff (!rst_n)
    fault_flag_out == fault_latch) else $error("flag pin mismatch");
  a_fault_levels: assert property (@(posedge clk) disable iff (!rst_n)
    $past(shut_now) && $past(rst_n) |-> gate_high == {PHASES{$past(fault_high_side_level)}})
    else $error("fault level wrong");
  a_allow_forces: assert property (@(posedge clk) disable iff (!rst_n)
    sync2[6] |=> gate_low == {PHASES{$past(fault_low_side_level)}})
    else $error("gate allow ignored");
  a_strap_ampl: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && sync2[1] |=> eff_amplitude[3:0] == BGFC_AMPL_LOW_FILL)
    else $error("amplitude fill wrong");
  a_reg_source: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !sync2[1] |=> eff_step_divider == $past(reg_step_divider))
    else $error("register source wrong");
endmodule : bgfc_top

// ### tb/bgfc_bridge_model.sv
/*
  Bridge model: gate drivers and half-bridge transistors on the gate pins.
  Assumes the real drivers follow the polarity pins given to it.
*/
`timescale 1ns/1ps
module bgfc_bridge_model
  import bgfc_pkg::*;
(
  // Gate pins and driver polarity
  input wire logic [BGFC_PHASES-1:0] gate_high,
  input wire logic [BGFC_PHASES-1:0] gate_low,
  input wire logic pol_high,
  input wire logic pol_low,
  input wire logic inject,
  // Driver error line, active low, and transistor states
  output logic error_n,
  output logic [BGFC_PHASES-1:0] hs_on,
  output logic [BGFC_PHASES-1:0] ls_on
);
  assign hs_on = pol_high ? gate_high : ~gate_high;
  assign ls_on = pol_low ? gate_low : ~gate_low;
  // shoot-through trips error
  // A missing dead time shows up as a latched fault, as on a real bridge
  assign error_n = ~(inject | (|(hs_on & ls_on)));
endmodule : bgfc_bridge_model

// ### tb/bgfc_top_tb.sv
/*
  Bench for the bridge gate and fault control block with a bridge model.
  Assumes a 250 MHz clock; inputs change at the falling edge.
*/
`timescale 1ns/1ps
module bgfc_top_tb;
  import bgfc_pkg::*;
  logic clk = 0, rst_n = 0, clk_en = 1, hp = 1, lp = 1, fhl = 0, fll = 0;
  logic f_hi = 0, f_lo_n, allow_n = 0, wr = 0, clr = 0, scheme = 1, fs = 0;
  logic inject = 0, sa = 0, flag, tick;
  logic [3:0] drv = 0, cmp_p = 0, cmp_n = 0, s_amp = 0, gh, gl, hs, ls;
  logic [1:0] s_dec = 0, rd = 0, dec, div, red, gain;
  logic [7:0] ra = 0, amp;
  int err_total = 0, checks = 0;

  // Clock, 4 ns period
  always #2 clk = ~clk;

  bgfc_top i_bgfc_top (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .high_side_polarity(hp), .low_side_polarity(lp), .fault_high_side_level(fhl),
    .fault_low_side_level(fll), .fault_in_active_high(f_hi), .fault_in_active_low(f_lo_n),
    .gate_allow_n(allow_n), .fault_ctrl_wr(wr), .fault_clear_bit(clr),
    .phase_scheme_select(scheme), .full_step_mode(fs), .phase_drive_high(drv),
    .comparator_pos_in(cmp_p), .comparator_neg_in(cmp_n), .reg_pwm_period(9'h03F),
    .reg_dead_time(8'h03), .reg_amplitude(ra), .reg_decay_select(rd),
    .reg_step_divider(rd + 2'h1), .reg_idle_reduction(rd + 2'h2),
    .reg_regulator_gain(rd + 2'h3), .standalone_en(sa), .strap_amplitude(s_amp),
    .strap_decay_select(s_dec), .strap_step_divider(s_dec + 2'h1),
    .strap_idle_reduction(s_dec + 2'h2), .strap_regulator_gain(s_dec + 2'h3),
    .gate_high(gh), .gate_low(gl), .fault_flag_out(flag), .pwm_period_tick(tick),
    .eff_amplitude(amp), .eff_decay_select(dec), .eff_step_divider(div),
    .eff_idle_reduction(red), .eff_regulator_gain(gain));

  bgfc_bridge_model i_bgfc_bridge_model (.gate_high(gh), .gate_low(gl), .pol_high(hp),
    .pol_low(lp), .inject(inject), .error_n(f_lo_n), .hs_on(hs), .ls_on(ls));

  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // Expected pins from wanted transistor states
  task automatic gates(input logic [3:0] on_h, input logic [3:0] on_l);
    chk({gh, gl}, {hp ? on_h : ~on_h, lp ? on_l : ~on_l});
  endtask : gates

  // One-cycle fault-control write
  task automatic clear(input logic b);
    wr = 1;
    clr = b;
    cyc(1);
    wr = 0;
    cyc(4);
  endtask : clear

  // Polarity changes trip the model until synced, so clear afterwards
  task automatic t_polarity;
    for (int p = 0; p < 5; p++) begin
      hp = (p == 4) | p[1];
      lp = (p == 4) | p[0];
      fhl = ~hp;
      fll = ~lp;
      drv = 4'h5;
      cyc(10);
      clear(1);
      cyc(30);
      gates(4'h5, 4'hA);
      drv = 4'hA;
      cyc(30);
      chk(flag, 16'h0);
      gates(4'hA, 4'h5);
    end
  endtask : t_polarity

  task automatic t_fault;
    fhl = 1;
    drv = 4'h3;
    cyc(30);
    f_hi = 1;
    cyc(1);
    gates(4'hF, 4'h0);
    cyc(2);
    chk(flag, 16'h1);
    f_hi = 0;
    cyc(8);
    chk(flag, 16'h1);
    gates(4'hF, 4'h0);
    clear(0);
    chk(flag, 16'h1);
    inject = 1;
    cyc(4);
    clear(1);
    chk(flag, 16'h1);
    inject = 0;
    cyc(4);
    clear(1);
    chk(flag, 16'h0);
    fhl = 0;
    cyc(30);
    gates(4'h3, 4'hC);
  endtask : t_fault

  task automatic t_allow;
    fll = 1;
    allow_n = 1;
    cyc(4);
    gates(4'h0, 4'hF);
    chk(flag, 16'h0);
    allow_n = 0;
    fll = 0;
    cyc(30);
    gates(4'h3, 4'hC);
  endtask : t_allow

  task automatic t_fullstep;
    drv = 4'hF;
    fs = 1;
    cmp_p = 4'h1;
    cyc(30);
    chk(gh[3:1], 16'h7);
    cmp_n = 4'h4;
    cyc(6);
    chk({gh[3:1], gl[3:1]}, 16'h0);
    cmp_p = 0;
    cmp_n = 0;
    scheme = 0;
    cyc(30);
    cmp_p = 4'h2;
    cyc(30);
    gates(4'hD, 4'h0);
    cmp_p = 0;
    fs = 0;
    cyc(30);
  endtask : t_fullstep

  // Every strap amplitude code and every decay code, straps then registers
  task automatic t_straps;
    for (int i = 0; i < 16; i++) begin
      sa = 1;
      s_amp = i[3:0];
      s_dec = i[1:0];
      ra = 8'h5A ^ i[7:0];
      rd = ~i[1:0];
      cyc(6);
      chk(amp, {s_amp, 4'hF});
      chk({dec, div, red, gain}, {s_dec, s_dec + 2'h1, s_dec + 2'h2, s_dec + 2'h3});
      sa = 0;
      cyc(6);
      chk({amp, dec, div, red, gain}, {ra, rd, rd + 2'h1, rd + 2'h2, rd + 2'h3});
    end
  endtask : t_straps

  // Dead time 3: both sides off for four cycles, then the low side comes on
  task automatic t_dead;
    drv = 4'h0;
    cyc(2);
    gates(4'h0, 4'h0);
    cyc(3);
    gates(4'h0, 4'h0);
    cyc(1);
    gates(4'h0, 4'hF);
  endtask : t_dead

  // Period 0x03F wraps every 64 edges; ten frozen edges stretch it to 74
  task automatic t_pwm;
    int n;
    n = 0;
    while (tick !== 1'b1) cyc(1);
    do begin
      cyc(1);
      n++;
    end while (tick !== 1'b1);
    chk(n[15:0], 16'd64);
    cyc(5);
    clk_en = 0;
    cyc(10);
    clk_en = 1;
    n = 15;
    do begin
      cyc(1);
      n++;
    end while (tick !== 1'b1);
    chk(n[15:0], 16'd74);
  endtask : t_pwm

  task automatic results;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  // Main sequence after 12 reset cycles
  initial begin
    cyc(12);
    rst_n = 1;
    cyc(4);
    t_polarity();
    t_fault();
    t_allow();
    t_fullstep();
    t_straps();
    t_dead();
    t_pwm();
    results();
  end

  // Watchdog, about five times the expected run of some 1000 cycles
  initial begin
    #20000;
    err_total++;
    results();
  end
endmodule : bgfc_top_tb
